// >>> rtl/hrd_decode.sv
// What this block does
// - Proxy for absent device 1: feature address write lands in device 0 feature.
// - Proxy: feature address read returns device 0 error register.
// - Proxy: sector count and LBA writes land in device 0 registers.
// - Proxy: sector count and LBA reads return registers, or zero with packet set.
// - Proxy: device/head write stored, new device-select bit acted on.
// - Proxy: device/head read has select bit forced one, or zero with packet set.
// - Proxy: command write stored, acted on only for execute diagnostics.
// - Proxy: command/status address read returns zero.
// - Selected only when device-select bit equals own device number.
// - Sleep: control write updates only soft reset, acts only when it is one.
// - Sleep without device reset: all else ignored, DMA request released.
// - Sleep with device reset: device/head write updates select bit only.
// - Sleep with device reset: command write ignored unless selected device reset.
// - Sleep with device reset: device/head and status reads ignored, bus undriven.
// - Sleep with device reset: other cycles, both selects equal, ignored.
// - Proxy: control write updates interrupt-disable and soft reset, acted on.
// - Control select alone accepts only address six.
`timescale 1ns/1ps
module hrd_decode
  import hrd_pkg::*;
#(
  parameter int         OWN_DEV_NUM    = 0,
  parameter bit         PACKET_IMPL    = 1'b0,
  parameter bit         DEV_RESET_IMPL = 1'b0,
  parameter logic [7:0] CMD_DIAG       = 8'h90,
  parameter logic [7:0] CMD_DEV_RESET  = 8'h08
)
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // Host register bus
  input  wire hrd_bus_t   host_bus,
  output logic [7:0]      dd_out,
  output logic            dd_oe_n,
  output logic            dmarq,
  output logic            dmarq_oe_n,
  // Device state
  input  wire logic       sleep_mode,
  input  wire logic       dev1_present,
  input  wire logic       busy,
  input  wire logic       data_req,
  input  wire logic [7:0] error_in,
  input  wire logic [7:0] status_in,
  // Register contents and events
  output hrd_regs_t       regs,
  output logic            ctl_nien,
  output logic            ctl_srst,
  output logic            srst_pulse,
  output logic            cmd_strobe,
  output logic            dev_reset_strobe,
  output logic            dev_selected,
  output hrd_mode_t       mode
);

  // Refused at elaboration: only device numbers 0 and 1 exist
  if (OWN_DEV_NUM < 0 || OWN_DEV_NUM > 1)
  begin : g_bad_own_dev
    $error("OWN_DEV_NUM must be 0 or 1");
  end

  localparam logic OWN_DEV = OWN_DEV_NUM[0];

  function automatic hrd_adr_t decode_adr(input logic cs0_n, input logic cs1_n,
                                          input logic [2:0] da);
    hrd_adr_t a;
    a = ADR_NONE;
    if (!cs0_n && cs1_n)
    begin
      case (da)
        DA_DATA: a = ADR_DATA;
        DA_FEAT: a = ADR_FEAT;
        DA_SCNT: a = ADR_SCNT;
        DA_LBAL: a = ADR_LBAL;
        DA_LBAM: a = ADR_LBAM;
        DA_LBAH: a = ADR_LBAH;
        DA_DEVH: a = ADR_DEVH;
        default: a = ADR_CMD;
      endcase
    end
    else if (cs0_n && !cs1_n && da == DA_CTL)
      a = ADR_CTL;
    return a;
  endfunction

  hrd_bus_t bus_q;

  // Writes are taken on strobe release, when data has settled
  wire        wr_evt  = !bus_q.diow_n && host_bus.diow_n;
  wire [7:0]  wr_data = bus_q.dd;
  hrd_adr_t   wr_adr;
  hrd_adr_t   rd_adr;
  assign wr_adr = decode_adr(bus_q.cs0_n, bus_q.cs1_n, bus_q.da);
  assign rd_adr = decode_adr(host_bus.cs0_n, host_bus.cs1_n, host_bus.da);
  wire        rd_act  = !host_bus.dior_n && host_bus.diow_n;

  wire dev_bit = regs.devh[DEVH_DEV_BIT];

  // Mode selection
  hrd_mode_t next_mode;
  assign next_mode = sleep_mode ? MODE_SLEEP :
                     (OWN_DEV == 1'b0 && !dev1_present && dev_bit && !busy && !data_req)
                     ? MODE_PROXY : MODE_NORMAL;

  wire in_sleep = (mode == MODE_SLEEP);
  wire in_proxy = (mode == MODE_PROXY);

  // Write qualifiers
  wire wr_std     = wr_evt && !in_sleep;
  wire wr_ctl_slp = wr_evt && in_sleep && wr_adr == ADR_CTL;
  wire wr_devh_sl = wr_evt && in_sleep && DEV_RESET_IMPL && wr_adr == ADR_DEVH;
  wire wr_cmd_sl  = wr_evt && in_sleep && DEV_RESET_IMPL && wr_adr == ADR_CMD
                    && dev_selected && wr_data == CMD_DEV_RESET;

  hrd_regs_t next_regs;
  always_comb
  begin
    next_regs = regs;
    if (wr_std)
    begin
      case (wr_adr)
        ADR_FEAT: next_regs.feature = wr_data;
        ADR_SCNT: next_regs.scnt    = wr_data;
        ADR_LBAL: next_regs.lbal    = wr_data;
        ADR_LBAM: next_regs.lbam    = wr_data;
        ADR_LBAH: next_regs.lbah    = wr_data;
        ADR_DEVH: next_regs.devh    = wr_data;
        ADR_CMD:  next_regs.cmd     = wr_data;
        default:  next_regs = regs;
      endcase
    end
    if (wr_devh_sl)
      next_regs.devh[DEVH_DEV_BIT] = wr_data[DEVH_DEV_BIT];
  end

  wire next_cmd_strobe = (wr_std && wr_adr == ADR_CMD &&
                         (!in_proxy || wr_data == CMD_DIAG));
  wire ctl_std         = wr_std && wr_adr == ADR_CTL;
  wire next_srst_pulse = (ctl_std || wr_ctl_slp) && wr_data[CTL_SRST_BIT];

  // Read answers; sleep leaves the bus released in every case
  logic [7:0] next_dd;
  logic       next_drive;
  wire  [7:0] pkt_mask = PACKET_IMPL ? ZERO_BYTE : 8'hff;
  wire  [7:0] dev_force = 8'h01 << DEVH_DEV_BIT;
  always_comb
  begin
    next_dd    = ZERO_BYTE;
    next_drive = rd_act && !in_sleep && rd_adr != ADR_NONE && rd_adr != ADR_DATA;
    case (rd_adr)
      ADR_FEAT: next_dd = error_in;
      ADR_SCNT: next_dd = in_proxy ? (regs.scnt & pkt_mask) : regs.scnt;
      ADR_LBAL: next_dd = in_proxy ? (regs.lbal & pkt_mask) : regs.lbal;
      ADR_LBAM: next_dd = in_proxy ? (regs.lbam & pkt_mask) : regs.lbam;
      ADR_LBAH: next_dd = in_proxy ? (regs.lbah & pkt_mask) : regs.lbah;
      ADR_DEVH: next_dd = in_proxy ? ((regs.devh | dev_force) & pkt_mask) : regs.devh;
      ADR_CMD:  next_dd = in_proxy ? ZERO_BYTE : status_in;
      ADR_CTL:  next_dd = in_proxy ? ZERO_BYTE : status_in;
      default:  next_dd = ZERO_BYTE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      bus_q            <= '{cs0_n: 1'b1, cs1_n: 1'b1, da: 3'h0, dior_n: 1'b1,
                            diow_n: 1'b1, dd: 8'h00};
      regs             <= '{default: REG_RST};
      ctl_nien         <= 1'b0;
      ctl_srst         <= 1'b0;
      srst_pulse       <= 1'b0;
      cmd_strobe       <= 1'b0;
      dev_reset_strobe <= 1'b0;
      dev_selected     <= (OWN_DEV == 1'b0);
      mode             <= MODE_NORMAL;
      dd_out           <= ZERO_BYTE;
      dd_oe_n          <= 1'b1;
      dmarq            <= 1'b0;
      dmarq_oe_n       <= 1'b1;
    end
    else
    begin
      bus_q            <= host_bus;
      regs             <= next_regs;
      if (ctl_std)
        ctl_nien       <= wr_data[CTL_NIEN_BIT];
      if (ctl_std || wr_ctl_slp)
        ctl_srst       <= wr_data[CTL_SRST_BIT];
      srst_pulse       <= next_srst_pulse;
      cmd_strobe       <= next_cmd_strobe;
      dev_reset_strobe <= wr_cmd_sl;
      dev_selected     <= (next_regs.devh[DEVH_DEV_BIT] == OWN_DEV);
      mode             <= next_mode;
      dd_out           <= next_dd;
      dd_oe_n          <= !next_drive;
      // No DMA in this decode: request always released
      dmarq            <= 1'b0;
      dmarq_oe_n       <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_proxy_wr(hrd_adr_t a);
    wr_evt && in_proxy && wr_adr == a;
  endsequence

  a_sleep_bus_idle: assert property (in_sleep |=> dd_oe_n)
    else $error("bus driven in sleep");
  a_dmarq_released: assert property (dmarq_oe_n && !dmarq)
    else $error("DMA request not released");
  a_proxy_cmd_read: assert property (in_proxy && rd_act && rd_adr == ADR_CMD
                                     |=> !dd_oe_n && dd_out == 8'h00)
    else $error("proxy status read not zero");
  a_proxy_cmd_act: assert property (s_proxy_wr(ADR_CMD) ##0 (wr_data != CMD_DIAG)
                                    |=> !cmd_strobe)
    else $error("proxy acted on non-diag command");
  a_proxy_feat_wr: assert property (s_proxy_wr(ADR_FEAT) |=> regs.feature == $past(wr_data))
    else $error("feature write lost");
  a_sleep_srst_one: assert property (wr_ctl_slp && wr_data[CTL_SRST_BIT]
                                     |=> srst_pulse && ctl_srst)
    else $error("sleep soft reset not acted on");
  a_sleep_nien_kept: assert property (in_sleep |=> $stable(ctl_nien))
    else $error("nien changed in sleep");
  a_sleep_devh_bit: assert property (in_sleep |=> $stable(regs.devh[7:5])
                                     && $stable(regs.devh[3:0]))
    else $error("devh changed beyond select bit");
  a_proxy_devh_rd: assert property (in_proxy && rd_act && rd_adr == ADR_DEVH && !PACKET_IMPL
                                    |=> dd_out[DEVH_DEV_BIT])
    else $error("proxy devh read select bit not one");
  a_both_cs_ign: assert property (!host_bus.cs0_n && !host_bus.cs1_n |=> dd_oe_n)
    else $error("both selects not ignored");
  a_sleep_devrst: assert property (dev_reset_strobe |-> $past(in_sleep && dev_selected))
    else $error("device reset without selection");
  a_select_match: assert property ($changed(regs.devh) |-> ##0
                                   dev_selected == (regs.devh[DEVH_DEV_BIT] == OWN_DEV))
    else $error("selection mismatch");

endmodule

// >>> rtl/hrd_pkg.sv
package hrd_pkg;
  // Command block addresses (chip select 0 asserted)
  localparam logic [2:0] DA_DATA = 3'h0;
  localparam logic [2:0] DA_FEAT = 3'h1;
  localparam logic [2:0] DA_SCNT = 3'h2;
  localparam logic [2:0] DA_LBAL = 3'h3;
  localparam logic [2:0] DA_LBAM = 3'h4;
  localparam logic [2:0] DA_LBAH = 3'h5;
  localparam logic [2:0] DA_DEVH = 3'h6;
  localparam logic [2:0] DA_CMD  = 3'h7;
  // Only valid control block address (chip select 1 asserted)
  localparam logic [2:0] DA_CTL  = 3'h6;

  // Field positions
  localparam int DEVH_DEV_BIT = 4;
  localparam int CTL_SRST_BIT = 2;
  localparam int CTL_NIEN_BIT = 1;

  // Reset values and fixed answers
  localparam logic [7:0] REG_RST   = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef enum logic [3:0] {
    ADR_NONE = 4'h0,
    ADR_DATA = 4'h1,
    ADR_FEAT = 4'h2,
    ADR_SCNT = 4'h3,
    ADR_LBAL = 4'h4,
    ADR_LBAM = 4'h5,
    ADR_LBAH = 4'h6,
    ADR_DEVH = 4'h7,
    ADR_CMD  = 4'h8,
    ADR_CTL  = 4'h9
  } hrd_adr_t;

  // Gray along normal -> proxy -> sleep
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_PROXY  = 2'b01,
    MODE_SLEEP  = 2'b11
  } hrd_mode_t;

  typedef struct packed {
    logic       cs0_n;
    logic       cs1_n;
    logic [2:0] da;
    logic       dior_n;
    logic       diow_n;
    logic [7:0] dd;
  } hrd_bus_t;

  typedef struct packed {
    logic [7:0] feature;
    logic [7:0] scnt;
    logic [7:0] lbal;
    logic [7:0] lbam;
    logic [7:0] lbah;
    logic [7:0] devh;
    logic [7:0] cmd;
  } hrd_regs_t;
endpackage

// >>> verif/hrd_host_model.sv
`timescale 1ns/1ps
module hrd_host_model
  import hrd_pkg::*;
(
  // Clock
  input  wire logic       sys_clk,
  // Register bus towards both devices
  output hrd_bus_t        bus,
  // Answers of both devices
  input  wire logic [7:0] dd_a,
  input  wire logic [7:0] dd_b,
  input  wire logic       oe_a_n,
  input  wire logic       oe_b_n
);
  initial
  begin
    bus = '{1'b1, 1'b1, 3'h0, 1'b1, 1'b1, 8'ha5};
  end

  // Strobe spans two edges; selects and address outlive its release by one edge
  task automatic cyc(input logic cs0_n, input logic cs1_n, input logic [2:0] da,
                     input logic wr, input logic [7:0] d, output logic [17:0] rd);
    begin
      @(negedge sys_clk);
      bus.cs0_n = cs0_n;
      bus.cs1_n = cs1_n;
      bus.da = da;
      bus.dd = wr ? d : ~bus.dd;
      bus.diow_n = !wr;
      bus.dior_n = wr;
      @(negedge sys_clk);
      @(negedge sys_clk);
      rd = {oe_b_n, dd_b, oe_a_n, dd_a};
      bus.diow_n = 1'b1;
      bus.dior_n = 1'b1;
      @(negedge sys_clk);
      bus.cs0_n = 1'b1;
      bus.cs1_n = 1'b1;
      bus.dd = ~bus.dd;
      @(negedge sys_clk);
    end
  endtask
endmodule

// >>> verif/test_host_register_decode_proxy_sleep.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    checked = checked + 1; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch = n_mismatch + 1; \
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
    end \
  end
module test_host_register_decode_proxy_sleep
  import hrd_pkg::*;
;
  logic        sys_clk, srst, sleep_mode, dev1_present, busy, data_req;
  logic [7:0]  error_in, status_in, dd_a, dd_b;
  logic        oe_a_n, oe_b_n;
  hrd_bus_t    host_bus;
  hrd_regs_t   regs [2];
  hrd_mode_t   mode [2];
  logic        nien [2], srst_o [2], pulse [2], cmds [2], drs [2], sel [2];
  logic        dmrq [2], dmoe [2];
  logic [17:0] rd;
  logic [7:0]  exp_a [7] = '{8'hc3, 8'h22, 8'h33, 8'h44, 8'h55, 8'h1a, 8'h00};
  logic [7:0]  exp_b [7] = '{8'hc3, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int          n_mismatch, checked, cycles;
  int          cmd_cnt [2], srst_cnt [2], drs_cnt [2];

  hrd_decode #(.PACKET_IMPL(1'b0), .DEV_RESET_IMPL(1'b1)) hrd_decode_i (
    .sys_clk(sys_clk), .srst(srst), .host_bus(host_bus), .dd_out(dd_a),
    .dd_oe_n(oe_a_n), .dmarq(dmrq[0]), .dmarq_oe_n(dmoe[0]), .sleep_mode(sleep_mode),
    .dev1_present(dev1_present), .busy(busy), .data_req(data_req), .error_in(error_in),
    .status_in(status_in), .regs(regs[0]), .ctl_nien(nien[0]), .ctl_srst(srst_o[0]),
    .srst_pulse(pulse[0]), .cmd_strobe(cmds[0]), .dev_reset_strobe(drs[0]),
    .dev_selected(sel[0]), .mode(mode[0]));
  // Second device: packet set, no device reset
  hrd_decode #(.PACKET_IMPL(1'b1), .DEV_RESET_IMPL(1'b0)) hrd_decode_b_i (
    .sys_clk(sys_clk), .srst(srst), .host_bus(host_bus), .dd_out(dd_b),
    .dd_oe_n(oe_b_n), .dmarq(dmrq[1]), .dmarq_oe_n(dmoe[1]), .sleep_mode(sleep_mode),
    .dev1_present(dev1_present), .busy(busy), .data_req(data_req), .error_in(error_in),
    .status_in(status_in), .regs(regs[1]), .ctl_nien(nien[1]), .ctl_srst(srst_o[1]),
    .srst_pulse(pulse[1]), .cmd_strobe(cmds[1]), .dev_reset_strobe(drs[1]),
    .dev_selected(sel[1]), .mode(mode[1]));
  hrd_host_model hrd_host_model_i (
    .sys_clk(sys_clk), .bus(host_bus), .dd_a(dd_a), .dd_b(dd_b),
    .oe_a_n(oe_a_n), .oe_b_n(oe_b_n));

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    begin
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  // Strobes stand one cycle; counting them lets checks after a cycle see them
  always @(posedge sys_clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      cmd_cnt[i] = cmd_cnt[i] + int'(cmds[i]);
      srst_cnt[i] = srst_cnt[i] + int'(pulse[i]);
      drs_cnt[i] = drs_cnt[i] + int'(drs[i]);
    end
  end

  // Whole run is about 150 cycles
  always @(posedge sys_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 3000)
    begin
      n_mismatch = n_mismatch + 1;
      end_of_test();
    end
  end

  initial
  begin
    srst = 1'b1;
    sleep_mode = 1'b0;
    dev1_present = 1'b0;
    busy = 1'b0;
    data_req = 1'b0;
    error_in = 8'hc3;
    status_in = 8'h3c;
    n_mismatch = 0;
    checked = 0;
    cycles = 0;
    repeat (5) @(negedge sys_clk);
    srst = 1'b0;
    `CHK("mode reset", MODE_NORMAL, mode[0])
    hrd_host_model_i.cyc(1'b0, 1'b1, DA_CMD, 1'b0, 8'h00, rd);
    `CHK("normal status", {1'b0, 8'h3c, 1'b0, 8'h3c}, rd)
    hrd_host_model_i.cyc(1'b0, 1'b1, DA_DEVH, 1'b1, 8'h1a, rd);
    @(negedge sys_clk);
    `CHK("mode", MODE_PROXY, mode[0])
    `CHK("selected", 1'b0, sel[0])
    for (int k = 0; k < 5; k++)
    begin
      hrd_host_model_i.cyc(1'b0, 1'b1, 3'(k + 1), 1'b1, k ? exp_a[k] : 8'h5a, rd);
      `CHK("stored", k ? exp_a[k] : 8'h5a, regs[0][8 * (6 - k) +: 8])
    end
    for (int k = 0; k < 7; k++)
    begin
      hrd_host_model_i.cyc(1'b0, 1'b1, 3'(k + 1), 1'b0, 8'h00, rd);
      `CHK("read a", {1'b0, exp_a[k]}, rd[8:0])
      `CHK("read b", {1'b0, exp_b[k]}, rd[17:9])
    end
    busy = 1'b1;
    repeat (2) @(negedge sys_clk);
    `CHK("mode busy", MODE_NORMAL, mode[0])
    busy = 1'b0;
    dev1_present = 1'b1;
    repeat (2) @(negedge sys_clk);
    `CHK("mode dev1", MODE_NORMAL, mode[0])
    dev1_present = 1'b0;
    @(negedge sys_clk);
    `CHK("mode back", MODE_PROXY, mode[0])
    hrd_host_model_i.cyc(1'b0, 1'b1, DA_CMD, 1'b1, 8'h20, rd);
    `CHK("cmd other", 16'h0020, {8'(cmd_cnt[0]), regs[0].cmd})
    hrd_host_model_i.cyc(1'b0, 1'b1, DA_CMD, 1'b1, 8'h90, rd);
    `CHK("cmd diag", 16'h0190, {8'(cmd_cnt[0]), regs[0].cmd})
    `CHK("cmd diag b", 8'h01, 8'(cmd_cnt[1]))
    hrd_host_model_i.cyc(1'b1, 1'b0, DA_CTL, 1'b1, 8'h06, rd);
    `CHK("control", 6'h31, {nien[0], srst_o[0], 4'(srst_cnt[0])})
    hrd_host_model_i.cyc(1'b1, 1'b0, 3'h5, 1'b0, 8'h00, rd);
    `CHK("cs1 bad read", 1'b1, rd[8])
    hrd_host_model_i.cyc(1'b1, 1'b0, 3'h7, 1'b1, 8'h00, rd);
    `CHK("cs1 bad write", 2'b11, {nien[0], srst_o[0]})
    // Host breaks the select rule on purpose here
    hrd_host_model_i.cyc(1'b0, 1'b0, DA_FEAT, 1'b0, 8'h00, rd);
    `CHK("both selects", 2'b11, {rd[17], rd[8]})
    sleep_mode = 1'b1;
    @(negedge sys_clk);
    `CHK("mode sleep", MODE_SLEEP, mode[0])
    hrd_host_model_i.cyc(1'b1, 1'b0, DA_CTL, 1'b1, 8'h00, rd);
    `CHK("sleep ctl 0", 6'h21, {nien[0], srst_o[0], 4'(srst_cnt[0])})
    hrd_host_model_i.cyc(1'b1, 1'b0, DA_CTL, 1'b1, 8'h04, rd);
    `CHK("sleep ctl 1", 6'h32, {nien[1], srst_o[1], 4'(srst_cnt[1])})
    // Device reset while device 0 is not yet selected
    hrd_host_model_i.cyc(1'b0, 1'b1, DA_CMD, 1'b1, 8'h08, rd);
    `CHK("sleep unsel", 8'h00, {4'(drs_cnt[0]), 4'(drs_cnt[1])})
    hrd_host_model_i.cyc(1'b0, 1'b1, DA_DEVH, 1'b1, 8'h00, rd);
    `CHK("sleep devh a", 9'h10a, {sel[0], regs[0].devh})
    `CHK("sleep devh b", 9'h01a, {sel[1], regs[1].devh})
    hrd_host_model_i.cyc(1'b0, 1'b1, DA_CMD, 1'b1, 8'h20, rd);
    `CHK("sleep cmd other", 16'h0190, {4'(drs_cnt[0]), 4'(cmd_cnt[0]), regs[0].cmd})
    hrd_host_model_i.cyc(1'b0, 1'b1, DA_CMD, 1'b1, 8'h08, rd);
    `CHK("dev reset", 16'h1011, {4'(drs_cnt[0]), 4'(drs_cnt[1]), 4'(cmd_cnt[0]), 4'(cmd_cnt[1])})
    hrd_host_model_i.cyc(1'b0, 1'b1, DA_CMD, 1'b0, 8'h00, rd);
    `CHK("sleep read", 2'b11, {rd[17], rd[8]})
    `CHK("dma request", 4'b1100, {dmoe[0], dmoe[1], dmrq[0], dmrq[1]})
    end_of_test();
  end
endmodule
